// ### pkg/dcd_pkg.sv
// Notes on behaviour
// - Commands decoded from pins at clock rise
// - Bank bits pick bank, or mode register
// - Four-beat bursts run to completion unless a new read or write restarts the count
// - Termination ignored by decode, off in self refresh
// - Self refresh exit caught without the clock
// - Power-down held by low, left by high
// - Self refresh held by low, left by high
// - Self refresh entry only with banks idle
// - Power-down entry active or precharge by banks
// - Clock enable held three registered edges
// - Commands ignored while asleep or powered down
// - Unlisted combinations are illegal
// - Mask low writes data, high blocks it
// - No-op and deselect decoding
// - No-op never stops a running burst
package dcd_pkg;

  // Decoded command codes
  typedef enum logic [3:0] {
    CMD_NOP = 4'h0,
    CMD_DES = 4'h1,
    CMD_MRS = 4'h2,
    CMD_REF = 4'h3,
    CMD_PRE = 4'h4,
    CMD_PREA = 4'h5,
    CMD_ACT = 4'h6,
    CMD_WR = 4'h7,
    CMD_WRA = 4'h8,
    CMD_RD = 4'h9,
    CMD_RDA = 4'hA,
    CMD_RSVD = 4'hB
  } dcd_cmd_t;

  // Power state, one-hot
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_APD = 4'h2,
    ST_PPD = 4'h4,
    ST_SREF = 4'h8
  } dcd_state_t;

  // Burst length in link clock edges
  localparam logic [2:0] BURST_LEN = 3'h4;
  // Least registrations of one clock enable level
  localparam logic [1:0] CKE_MIN_CLK = 2'h3;
  // Link clocks after self refresh exit before a read
  localparam logic [7:0] XSRD_CLK = 8'hC8;
  // Reset values
  localparam logic CKE_PREV_RST = 1'b0;
  localparam logic [2:0] BEAT_RST = 3'h0;
  localparam logic [7:0] XSRD_RST = 8'h00;

endpackage

// ### verilog/dcd_decoder.sv
`timescale 1ns/1ps
module dcd_decoder #(
  parameter int AW = 14,
  parameter int BW = 3,
  parameter int DW = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CK,
  input wire logic CKE,
  input wire logic CS_N,
  input wire logic RAS_N,
  input wire logic CAS_N,
  input wire logic WE_N,
  input wire logic [BW-1:0] BA,
  input wire logic [AW-1:0] ADDR,
  input wire logic ODT,
  input wire logic DM,
  input wire logic [DW-1:0] DQ,
  output dcd_pkg::dcd_cmd_t CMD,
  output logic CMD_VALID,
  output logic [BW-1:0] BANK,
  output logic [BW-1:0] MR_SEL,
  output logic [AW-1:0] CMD_ADDR,
  output logic WR_VALID,
  output logic WR_EN,
  output logic [DW-1:0] WR_DATA,
  output dcd_pkg::dcd_state_t PWR_STATE,
  output logic ODT_ACTIVE,
  output logic BURST_BUSY,
  output logic ILLEGAL
);
  import dcd_pkg::*;

  localparam int NB = 1 << BW;

  logic [1:0] lrst_ff;
  logic lrst;
  logic cke_prev_ff;
  logic [1:0] cke_run_ff;
  logic [1:0] nxt_cke_run;
  dcd_state_t st_ff;
  dcd_state_t nxt_st;
  logic [NB-1:0] open_ff;
  logic [NB-1:0] nxt_open;
  logic [2:0] beat_ff;
  logic [2:0] nxt_beat;
  logic wr_burst_ff;
  logic nxt_wr_burst;
  logic [7:0] xsrd_ff;
  logic [7:0] nxt_xsrd;
  logic ill_ff;
  logic nxt_ill;
  dcd_cmd_t cmd;
  logic is_nop;
  logic wake_tog_ff;
  logic wake_s1_ff;
  logic wake_s2_ff;
  logic wake_s3_ff;
  logic wake;
  logic l_tog_ff;
  dcd_cmd_t b_cmd_ff;
  logic [BW-1:0] b_ba_ff;
  logic [AW-1:0] b_addr_ff;
  logic b_wv_ff;
  logic b_wen_ff;
  logic [DW-1:0] b_data_ff;
  dcd_state_t b_st_ff;
  logic b_odt_ff;
  logic b_busy_ff;
  logic b_ill_ff;
  logic t1_ff;
  logic t2_ff;
  logic t3_ff;
  logic slot;

  // Link reset: asserts at once, releases on the link clock
  always_ff @(posedge CK or posedge RST) begin
    if (RST) begin
      lrst_ff <= 2'h3;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b0};
    end
  end
  assign lrst = lrst_ff[1];

  // Command decode from the pin levels at this edge
  always_comb begin
    is_nop = CS_N | (RAS_N & CAS_N & WE_N);
    cmd = CMD_RSVD;
    if (CS_N) begin
      cmd = CMD_DES;
    end else begin
      case ({RAS_N, CAS_N, WE_N})
        3'h0: cmd = CMD_MRS;
        3'h1: cmd = CMD_REF;
        3'h2: cmd = ADDR[10] ? CMD_PREA : CMD_PRE;
        3'h3: cmd = CMD_ACT;
        3'h4: cmd = ADDR[10] ? CMD_WRA : CMD_WR;
        3'h5: cmd = ADDR[10] ? CMD_RDA : CMD_RD;
        3'h7: cmd = CMD_NOP;
        default: cmd = CMD_RSVD;
      endcase
    end
  end

  // Self refresh exit seen on the enable edge itself, no clock needed
  always_ff @(posedge CKE or posedge RST) begin
    if (RST) begin
      wake_tog_ff <= 1'b0;
    end else if (st_ff == ST_SREF) begin
      wake_tog_ff <= ~wake_tog_ff;
    end
  end

  // Wake toggle into the link domain
  always_ff @(posedge CK or posedge RST) begin
    if (RST) begin
      wake_s1_ff <= 1'b0;
      wake_s2_ff <= 1'b0;
      wake_s3_ff <= 1'b0;
    end else begin
      wake_s1_ff <= wake_tog_ff;
      wake_s2_ff <= wake_s1_ff;
      wake_s3_ff <= wake_s2_ff;
    end
  end
  assign wake = wake_s2_ff ^ wake_s3_ff;

  // Clock enable state, banks, bursts and illegal detection
  always_comb begin
    nxt_st = st_ff;
    nxt_open = open_ff;
    nxt_beat = (beat_ff != BEAT_RST) ? beat_ff - 3'h1 : beat_ff;
    nxt_wr_burst = (beat_ff > 3'h1) ? wr_burst_ff : 1'b0;
    nxt_xsrd = (xsrd_ff != XSRD_RST) ? xsrd_ff - 8'h01 : xsrd_ff;
    nxt_ill = ill_ff;
    nxt_cke_run = (CKE != cke_prev_ff) ? 2'h1 :
                  ((cke_run_ff < CKE_MIN_CLK) ? cke_run_ff + 2'h1 : cke_run_ff);
    if ((CKE != cke_prev_ff) && (cke_run_ff < CKE_MIN_CLK)) begin
      nxt_ill = 1'b1;
    end
    case (st_ff)
      ST_RUN: begin
        if (cke_prev_ff && !CKE) begin
          if (cmd == CMD_REF) begin
            if ((open_ff == '0) && (beat_ff == BEAT_RST)) begin
              nxt_st = ST_SREF;
            end else begin
              nxt_ill = 1'b1;
            end
          end else if (is_nop) begin
            if (beat_ff != BEAT_RST) begin
              nxt_ill = 1'b1;
            end
            nxt_st = (open_ff != '0) ? ST_APD : ST_PPD;
          end else begin
            nxt_ill = 1'b1;
          end
        end else if (cke_prev_ff && CKE) begin
          case (cmd)
            CMD_ACT: nxt_open[BA] = 1'b1;
            CMD_PRE: nxt_open[BA] = 1'b0;
            CMD_PREA: nxt_open = '0;
            CMD_WR, CMD_WRA, CMD_RD, CMD_RDA: begin
              if (beat_ff != BEAT_RST) begin
                nxt_ill = 1'b1;
              end
              if ((cmd == CMD_RD || cmd == CMD_RDA) && xsrd_ff != XSRD_RST) begin
                nxt_ill = 1'b1;
              end
              nxt_beat = BURST_LEN;
              nxt_wr_burst = (cmd == CMD_WR) || (cmd == CMD_WRA);
              if (cmd == CMD_WRA || cmd == CMD_RDA) begin
                nxt_open[BA] = 1'b0;
              end
            end
            CMD_RSVD: nxt_ill = 1'b1;
            default: nxt_ill = nxt_ill;
          endcase
        end
      end
      ST_APD, ST_PPD: begin
        if (CKE) begin
          nxt_st = ST_RUN;
          if (!is_nop) begin
            nxt_ill = 1'b1;
          end
        end
      end
      ST_SREF: begin
        if (wake || CKE) begin
          nxt_st = ST_RUN;
          nxt_xsrd = XSRD_CLK;
          if (!is_nop) begin
            nxt_ill = 1'b1;
          end
        end
      end
      default: begin
        nxt_st = ST_RUN;
        nxt_ill = 1'b1;
      end
    endcase
  end

  // Link state registers; asleep, command pins have no effect
  always_ff @(posedge CK or posedge lrst) begin
    if (lrst) begin
      st_ff <= ST_RUN;
      open_ff <= '0;
      beat_ff <= BEAT_RST;
      wr_burst_ff <= 1'b0;
      xsrd_ff <= XSRD_RST;
      ill_ff <= 1'b0;
      cke_prev_ff <= CKE_PREV_RST;
      cke_run_ff <= CKE_MIN_CLK;
    end else begin
      st_ff <= nxt_st;
      open_ff <= nxt_open;
      beat_ff <= nxt_beat;
      wr_burst_ff <= nxt_wr_burst;
      xsrd_ff <= nxt_xsrd;
      ill_ff <= nxt_ill;
      cke_prev_ff <= CKE;
      cke_run_ff <= nxt_cke_run;
    end
  end

  // Per-edge bundle held stable for a whole link period
  always_ff @(posedge CK or posedge lrst) begin
    if (lrst) begin
      l_tog_ff <= 1'b0;
      b_cmd_ff <= CMD_NOP;
      b_ba_ff <= '0;
      b_addr_ff <= '0;
      b_wv_ff <= 1'b0;
      b_wen_ff <= 1'b0;
      b_data_ff <= '0;
      b_st_ff <= ST_RUN;
      b_odt_ff <= 1'b0;
      b_busy_ff <= 1'b0;
      b_ill_ff <= 1'b0;
    end else begin
      l_tog_ff <= ~l_tog_ff;
      b_cmd_ff <= (st_ff == ST_RUN && cke_prev_ff && CKE) ? cmd : CMD_NOP;
      b_ba_ff <= BA;
      b_addr_ff <= ADDR;
      b_wv_ff <= wr_burst_ff && (beat_ff != BEAT_RST);
      b_wen_ff <= ~DM;
      b_data_ff <= DQ;
      b_st_ff <= nxt_st;
      b_odt_ff <= ODT && (nxt_st != ST_SREF);
      b_busy_ff <= nxt_beat != BEAT_RST;
      b_ill_ff <= nxt_ill;
    end
  end

  // Slot toggle into the system clock domain
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      t1_ff <= 1'b0;
      t2_ff <= 1'b0;
      t3_ff <= 1'b0;
    end else begin
      t1_ff <= l_tog_ff;
      t2_ff <= t1_ff;
      t3_ff <= t2_ff;
    end
  end
  assign slot = t2_ff ^ t3_ff;

  // Command outputs, pulses for one system clock per slot
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CMD <= CMD_NOP;
      CMD_VALID <= 1'b0;
      BANK <= '0;
      MR_SEL <= '0;
      CMD_ADDR <= '0;
    end else begin
      CMD_VALID <= slot && (b_cmd_ff != CMD_NOP) && (b_cmd_ff != CMD_DES);
      if (slot) begin
        CMD <= b_cmd_ff;
        CMD_ADDR <= b_addr_ff;
        if (b_cmd_ff == CMD_MRS) begin
          MR_SEL <= b_ba_ff;
        end else begin
          BANK <= b_ba_ff;
        end
      end
    end
  end

  // Write beat outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      WR_VALID <= 1'b0;
      WR_EN <= 1'b0;
      WR_DATA <= '0;
    end else begin
      WR_VALID <= slot && b_wv_ff;
      if (slot && b_wv_ff) begin
        WR_EN <= b_wen_ff;
        WR_DATA <= b_data_ff;
      end
    end
  end

  // Status outputs
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PWR_STATE <= ST_RUN;
      ODT_ACTIVE <= 1'b0;
      BURST_BUSY <= 1'b0;
      ILLEGAL <= 1'b0;
    end else if (slot) begin
      PWR_STATE <= b_st_ff;
      ODT_ACTIVE <= b_odt_ff;
      BURST_BUSY <= b_busy_ff;
      ILLEGAL <= b_ill_ff;
    end
  end

endmodule

// ### tb/dcd_decoder_asserts.sv
`timescale 1ns/1ps
module dcd_decoder_asserts (
  input wire logic CLK,
  input wire logic RST,
  input dcd_pkg::dcd_cmd_t CMD,
  input wire logic CMD_VALID,
  input wire logic WR_VALID,
  input dcd_pkg::dcd_state_t PWR_STATE,
  input wire logic ODT_ACTIVE,
  input wire logic BURST_BUSY,
  input wire logic ILLEGAL
);
  import dcd_pkg::*;
  // All checks run on the system clock and rest during reset
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  one_hot_state_a: assert property ($onehot(PWR_STATE))
    else $error("power state not one-hot");
  cmd_pulse_a: assert property (CMD_VALID |=> !CMD_VALID)
    else $error("command strobe longer than one cycle");
  beat_pulse_a: assert property (WR_VALID |=> !WR_VALID)
    else $error("beat strobe longer than one cycle");
  no_op_quiet_a: assert property (CMD_VALID |-> !(CMD inside {CMD_NOP, CMD_DES}))
    else $error("idle command flagged as valid");
  awake_cmd_a: assert property (CMD_VALID |-> PWR_STATE == ST_RUN)
    else $error("command taken while asleep");
  sref_odt_off_a: assert property (
    PWR_STATE == ST_SREF && $past(PWR_STATE) == ST_SREF |-> !ODT_ACTIVE)
    else $error("termination on in self refresh");
  sref_from_run_a: assert property (
    $changed(PWR_STATE) && PWR_STATE == ST_SREF |-> $past(PWR_STATE) == ST_RUN)
    else $error("self refresh entered from sleep");
  sref_exit_run_a: assert property (
    $past(PWR_STATE) == ST_SREF && PWR_STATE != ST_SREF |-> PWR_STATE == ST_RUN)
    else $error("self refresh left to wrong state");
  pd_exit_run_a: assert property (
    $past(PWR_STATE) inside {ST_APD, ST_PPD} && $changed(PWR_STATE) |-> PWR_STATE == ST_RUN)
    else $error("power-down left to wrong state");
  burst_hold_a: assert property ($rose(BURST_BUSY) |-> BURST_BUSY [*8])
    else $error("burst cut short");
  flag_sticky_a: assert property (ILLEGAL |=> ILLEGAL)
    else $error("illegal flag dropped");
  // Main scenarios
  cover property (CMD_VALID && CMD == CMD_WR);
  cover property (PWR_STATE == ST_SREF);
  cover property ($rose(ILLEGAL));
endmodule
bind dcd_decoder dcd_decoder_asserts u_chk (.CLK(CLK), .RST(RST), .CMD(CMD),
  .CMD_VALID(CMD_VALID), .WR_VALID(WR_VALID), .PWR_STATE(PWR_STATE),
  .ODT_ACTIVE(ODT_ACTIVE), .BURST_BUSY(BURST_BUSY), .ILLEGAL(ILLEGAL));

// ### tb/dcd_ctrl_model.sv
`timescale 1ns/1ps
module dcd_ctrl_model (
  output logic CK,
  output logic CKE,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [2:0] BA,
  output logic [13:0] ADDR,
  output logic ODT,
  output logic DM,
  output logic [7:0] DQ
);
  logic ck_en = 1'b1;
  // Idle pins, clock enable low, termination held valid
  initial begin
    {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, ODT, DM, DQ} = {6'h0F, 17'h0, 1'b1, 9'h0};
  end
  // Link clock; stops only when asked during self refresh
  always #62.5 CK = ck_en & ~CK;
  // One slot: pins change after a rise and hold a full period
  task automatic put(input logic k, input logic [3:0] c, input logic a,
    input logic [2:0] b, input logic [8:0] d);
    @(posedge CK);
    #2;
    CKE = k;
    {CS_N, RAS_N, CAS_N, WE_N} = c;
    ADDR = {3'h0, a, 10'h000};
    BA = b;
    {DM, DQ} = d;
  endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import dcd_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ck, cke, cs_n, ras_n, cas_n, we_n, odt, dm, cmd_valid, wr_valid, wr_en;
  logic odt_active, illegal, burst_busy;
  logic [2:0] ba, bank, mr_sel;
  logic [13:0] addr, cmd_addr;
  logic [7:0] dq, wr_data;
  dcd_cmd_t cmd;
  dcd_state_t pwr_state;
  int err_total = 0;
  int tests_run = 0;
  logic [3:0] cq [$];
  logic [8:0] wq [$];
  logic aq [$];
  always #10 clk = ~clk;
  dcd_ctrl_model pm (.CK(ck), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n),
    .WE_N(we_n), .BA(ba), .ADDR(addr), .ODT(odt), .DM(dm), .DQ(dq));
  dcd_decoder dut (.CLK(clk), .RST(rst), .CK(ck), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .ADDR(addr), .ODT(odt), .DM(dm), .DQ(dq),
    .CMD(cmd), .CMD_VALID(cmd_valid), .BANK(bank), .MR_SEL(mr_sel), .CMD_ADDR(cmd_addr),
    .WR_VALID(wr_valid), .WR_EN(wr_en), .WR_DATA(wr_data), .PWR_STATE(pwr_state),
    .ODT_ACTIVE(odt_active), .BURST_BUSY(burst_busy), .ILLEGAL(illegal));
  // Log decoded commands and write beats as they appear
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      cq.push_back(cmd);
      aq.push_back(cmd_addr[10]);
    end
    if (wr_valid === 1'b1) wq.push_back({wr_en, wr_data});
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Repeated slots; released data lines show the inverse of their last value
  task automatic run(input int n, input logic k, input logic [3:0] c);
    repeat (n) pm.put(k, c, 1'b0, ba, ~{dm, dq});
  endtask
  // Each command code from MRS to RDA once, four no-op or deselect slots with data after it
  task automatic t_cmds();
    logic [3:0] pin [9] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5};
    cq.delete();
    aq.delete();
    for (int i = 0; i < 9; i++) begin
      pm.put(1'b1, pin[i], i inside {3, 6, 8}, 3'(i / 2 + 1), 9'h000);
      for (int k = 1; k < 5; k++) pm.put(1'b1, k[0] ? 4'h8 : 4'h7, 1'b0, ba, {k[0], 8'(16 * i + k)});
    end
    run(2, 1'b1, 4'h7);
    chk(32'(cq.size()), 9);
    foreach (cq[i]) chk(32'(cq[i]), 32'(i + 2));
    chk(32'(wq.size()), 8);
    foreach (wq[j]) chk(32'(wq[j]), 32'({j[0], 8'(8'h51 + j % 4 + j / 4 * 16)}));
    chk(32'(mr_sel), 1);
    chk(32'(bank), 5);
    foreach (aq[i]) chk(32'(aq[i]), 32'(i inside {3, 6, 8}));
    chk(32'(burst_busy), 0);
  endtask
  // Active power-down with a bank open, then precharge power-down
  task automatic t_pd();
    run(3, 1'b0, 4'h7);
    chk(32'(pwr_state), 32'(ST_APD));
    run(3, 1'b1, 4'h8);
    chk(32'(pwr_state), 32'(ST_RUN));
    cq.delete();
    pm.put(1'b1, 4'h2, 1'b1, ba, 9'h000);
    run(1, 1'b0, 4'h7);
    run(2, 1'b0, 4'h4);
    chk(32'(pwr_state), 32'(ST_PPD));
    run(3, 1'b1, 4'h7);
    chk(32'(pwr_state), 32'(ST_RUN));
    chk(32'(cq.size()), 1);
    chk(32'(cq[0]), 32'(CMD_PREA));
  endtask
  // Self refresh with the link clock stopped, wake, then an early read
  task automatic t_sref();
    pm.put(1'b0, 4'h1, 1'b0, ba, 9'h000);
    run(3, 1'b0, 4'hF);
    chk(32'(pwr_state), 32'(ST_SREF));
    chk(32'(odt_active), 0);
    pm.ck_en = 1'b0;
    #300 pm.CKE = 1'b1;
    #300 pm.ck_en = 1'b1;
    run(4, 1'b1, 4'h7);
    chk(32'(pwr_state), 32'(ST_RUN));
    chk(32'(odt_active), 1);
    chk(32'(illegal), 0);
    pm.put(1'b1, 4'h5, 1'b0, ba, 9'h000);
    run(3, 1'b1, 4'h7);
    chk(32'(illegal), 1);
    chk(32'(burst_busy), 1);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    chk(32'(pwr_state), 32'(ST_RUN));
    chk(32'(illegal), 0);
    #2 rst = 1'b0;
    run(5, 1'b1, 4'h7);
    t_cmds();
    t_pd();
    t_sref();
    give_verdict();
  end
  // Cut a hang short
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
endmodule
